// >>> rtl/scb_security_id_csr_bank.sv
// Security feature control, seed, identity and security config CSRs.
// Assumes the core presents one CSR access per cycle and takes the
// read data, hit and illegal flags one cycle later.
`timescale 1ns/10ps
`default_nettype none
module scb_security_id_csr_bank
    import scb_pkg::*;
#(
    parameter bit LEVEL_INTC_EN = 1'b1,
    parameter int PROT_REGION_COUNT = 4,
    // Identity defaults are arbitrary neutral values; integrators override them
    parameter logic [31:0] VENDOR_ID = 32'h00000abc,
    parameter logic [31:0] ARCH_ID = 32'h00000123,
    parameter logic [3:0] IMPL_MAJOR = 4'h0,
    parameter logic [3:0] IMPL_MINOR = 4'h0
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic csr_access,
    input wire logic [11:0] csr_addr,
    input wire scb_op_t csr_op,
    input wire logic csr_imm,
    input wire logic csr_src_x0,
    input wire logic [31:0] csr_wdata,
    output logic [31:0] csr_rdata,
    output logic csr_rvalid,
    output logic csr_hit,
    output logic csr_illegal,
    input wire logic [31:0] hart_id_in,
    input wire logic [3:0] impl_patch_in,
    input wire logic [7:0] machine_level_active_in,
    input wire logic instr_retired,
    input wire logic hint_valid,
    input wire logic [15:0] hint_instr,
    output logic constant_time_enable,
    output logic dummy_insert_enable,
    output logic random_hint_replace,
    output logic pc_hardening_enable,
    output logic integrity_check_enable,
    output logic [3:0] dummy_insert_interval,
    output logic dummy_insert_req,
    output logic hint_swap,
    output logic [31:0] hint_swap_instr,
    output logic whitelist_policy,
    output logic machine_lockdown,
    output logic rule_lock_bypass,
    output logic major_alert
);
    function automatic logic [31:0] scb_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input scb_op_t op);
        case (op)
            SCB_OP_WRITE: scb_merge = wd;
            SCB_OP_SET: scb_merge = old | wd;
            SCB_OP_CLEAR: scb_merge = old & ~wd;
            default: scb_merge = old;
        endcase
    endfunction

    function automatic logic [31:0] scb_lfsr_next(input logic [31:0] s);
        scb_lfsr_next = s[0] ? ((s >> 1) ^ SCB_LFSR_POLY) : (s >> 1);
    endfunction

    logic [31:0] cpuctrl_q;
    logic [31:0] cpuctrl_sh_q;
    logic [2:0] seccfg_q;
    logic [2:0] seccfg_sh_q;
    logic [7:0] mil_q;
    logic [7:0] mil_sh_q;
    logic [31:0] prng_first_q;
    logic [31:0] prng_second_q;
    logic [31:0] prng_third_q;
    logic [6:0] dummy_cnt_q;
    logic [6:0] dummy_target_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic hit_q;
    logic illegal_q;
    logic alert_q;
    logic dummy_req_q;
    logic hint_swap_q;
    logic [31:0] hint_instr_q;

    // Address decode
    wire sel_cpuctrl = csr_addr == SCB_ADDR_CPUCTRL;
    wire sel_seccfg = csr_addr == SCB_ADDR_SECCFG;
    wire sel_seccfgh = csr_addr == SCB_ADDR_SECCFGH;
    wire sel_perf_hi = csr_addr >= SCB_ADDR_PERF_HI_FIRST && csr_addr <= SCB_ADDR_PERF_HI_LAST;
    wire sel_seed0 = csr_addr == SCB_ADDR_SEED0;
    wire sel_seed1 = csr_addr == SCB_ADDR_SEED1;
    wire sel_seed2 = csr_addr == SCB_ADDR_SEED2;
    wire sel_seed = sel_seed0 | sel_seed1 | sel_seed2;
    wire sel_vendor = csr_addr == SCB_ADDR_VENDOR;
    wire sel_arch = csr_addr == SCB_ADDR_ARCH;
    wire sel_impl = csr_addr == SCB_ADDR_IMPL;
    wire sel_hart = csr_addr == SCB_ADDR_HART;
    wire sel_cfgptr = csr_addr == SCB_ADDR_CFGPTR;
    wire sel_intstat = LEVEL_INTC_EN && csr_addr == SCB_ADDR_INTSTAT;
    wire hit_now = sel_cpuctrl | sel_seccfg | sel_seccfgh | sel_perf_hi | sel_seed
                   | sel_vendor | sel_arch | sel_impl | sel_hart | sel_cfgptr | sel_intstat;

    // Seeds accept only the register-source swap form
    wire illegal_now = csr_access && sel_seed
                       && (csr_op != SCB_OP_WRITE || csr_imm || csr_src_x0);
    wire wr_now = csr_access && csr_op != SCB_OP_NONE && !illegal_now;

    wire [31:0] cpuctrl_wv = scb_merge(cpuctrl_q, csr_wdata, csr_op) & SCB_CPUCTRL_MASK;
    wire [31:0] cpuctrl_d = (wr_now && sel_cpuctrl) ? cpuctrl_wv : cpuctrl_q;

    wire [31:0] seccfg_ext = {29'h0, seccfg_q};
    wire [31:0] seccfg_mv = scb_merge(seccfg_ext, csr_wdata, csr_op);
    // Lockdown and whitelist can only be set by software
    wire [2:0] seccfg_wv = {seccfg_mv[SCB_RLB_BIT], seccfg_mv[SCB_WL_BIT] | seccfg_q[SCB_WL_BIT],
                            seccfg_mv[SCB_ML_BIT] | seccfg_q[SCB_ML_BIT]};
    wire [2:0] seccfg_d = (PROT_REGION_COUNT == 0) ? 3'h0 :
                          (wr_now && sel_seccfg) ? seccfg_wv : seccfg_q;
    wire [7:0] mil_d = LEVEL_INTC_EN ? machine_level_active_in : 8'h00;

    wire [31:0] impl_val = {12'h000, IMPL_MAJOR, 4'h0, IMPL_MINOR, 4'h0, impl_patch_in};
    // Seeds, counter halves, pointer and upper config fall through to zero
    wire [31:0] rd_mux = sel_cpuctrl ? cpuctrl_q :
                         sel_seccfg ? seccfg_ext :
                         sel_vendor ? VENDOR_ID :
                         sel_arch ? ARCH_ID :
                         sel_impl ? impl_val :
                         sel_hart ? hart_id_in :
                         sel_intstat ? {mil_q, 24'h000000} : 32'h00000000;

    wire shadow_bad = (cpuctrl_q != ~cpuctrl_sh_q) || (seccfg_q != ~seccfg_sh_q)
                      || (mil_q != ~mil_sh_q);

    // Dummy spacing: n uniform over 1..4*(field+1) when field is 0, 1, 3, 7 or 15
    wire [5:0] interval_mask = {cpuctrl_q[SCB_INTERVAL_LSB +: 4], 2'b11};
    wire [6:0] next_target = {1'b0, prng_first_q[5:0] & interval_mask} + 7'h01;
    wire dummy_fire = dummy_insert_enable && instr_retired
                      && (dummy_cnt_q + 7'h01 >= dummy_target_q);

    wire hint_match = random_hint_replace && hint_valid && hint_instr[1:0] == 2'b10
                      && hint_instr[15:13] == 3'b000 && hint_instr[11:7] == 5'h00
                      && {hint_instr[12], hint_instr[6:2]} != 6'h00;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpuctrl_q <= SCB_CPUCTRL_RESET;
            cpuctrl_sh_q <= ~SCB_CPUCTRL_RESET;
            seccfg_q <= SCB_SECCFG_RESET;
            seccfg_sh_q <= ~SCB_SECCFG_RESET;
            mil_q <= 8'h00;
            mil_sh_q <= 8'hff;
        end
        else
        begin
            cpuctrl_q <= cpuctrl_d;
            cpuctrl_sh_q <= ~cpuctrl_d;
            seccfg_q <= seccfg_d;
            seccfg_sh_q <= ~seccfg_d;
            mil_q <= mil_d;
            mil_sh_q <= ~mil_d;
        end
    end

    // Generators free-run; a swap write reseeds, zero reseeds to default
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            prng_first_q <= SCB_SEED0_RESET;
            prng_second_q <= SCB_SEED1_RESET;
            prng_third_q <= SCB_SEED2_RESET;
        end
        else
        begin
            prng_first_q <= (wr_now && sel_seed0) ? (csr_wdata != 32'h0 ? csr_wdata : SCB_SEED0_RESET)
                            : scb_lfsr_next(prng_first_q);
            prng_second_q <= (wr_now && sel_seed1) ? (csr_wdata != 32'h0 ? csr_wdata : SCB_SEED1_RESET)
                             : scb_lfsr_next(prng_second_q);
            prng_third_q <= (wr_now && sel_seed2) ? (csr_wdata != 32'h0 ? csr_wdata : SCB_SEED2_RESET)
                            : scb_lfsr_next(prng_third_q);
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            dummy_cnt_q <= 7'h00;
            dummy_target_q <= 7'h04;
            dummy_req_q <= 1'b0;
        end
        else
        begin
            dummy_req_q <= dummy_fire;
            if (!dummy_insert_enable)
                dummy_cnt_q <= 7'h00;
            else if (dummy_fire)
            begin
                dummy_cnt_q <= 7'h00;
                dummy_target_q <= next_target;
            end
            else if (instr_retired)
                dummy_cnt_q <= dummy_cnt_q + 7'h01;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            hint_swap_q <= 1'b0;
            hint_instr_q <= 32'h00000000;
        end
        else
        begin
            hint_swap_q <= hint_match;
            if (hint_match)
                hint_instr_q <= {prng_second_q[31:15], 3'b000, 5'h00, SCB_OPC_OPIMM};
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
            hit_q <= 1'b0;
            illegal_q <= 1'b0;
            alert_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= csr_access;
            hit_q <= csr_access && hit_now;
            illegal_q <= illegal_now;
            rdata_q <= csr_access ? rd_mux : 32'h00000000;
            alert_q <= shadow_bad;
        end
    end

    assign csr_rdata = rdata_q;
    assign csr_rvalid = rvalid_q;
    assign csr_hit = hit_q;
    assign csr_illegal = illegal_q;
    assign constant_time_enable = cpuctrl_q[SCB_CT_BIT];
    assign dummy_insert_enable = cpuctrl_q[SCB_DUMMY_EN_BIT];
    assign random_hint_replace = cpuctrl_q[SCB_HINT_BIT];
    assign pc_hardening_enable = cpuctrl_q[SCB_PCH_BIT];
    assign integrity_check_enable = cpuctrl_q[SCB_INTEG_BIT];
    assign dummy_insert_interval = cpuctrl_q[SCB_INTERVAL_LSB +: 4];
    assign dummy_insert_req = dummy_req_q;
    assign hint_swap = hint_swap_q;
    assign hint_swap_instr = hint_instr_q;
    assign whitelist_policy = seccfg_q[SCB_WL_BIT];
    assign machine_lockdown = seccfg_q[SCB_ML_BIT];
    assign rule_lock_bypass = seccfg_q[SCB_RLB_BIT];
    assign major_alert = alert_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_cpu_write;
        csr_access && sel_cpuctrl && csr_op == SCB_OP_WRITE;
    endsequence

    sequence s_seed_bad;
        csr_access && sel_seed && (csr_imm || csr_op != SCB_OP_WRITE);
    endsequence

    // Register-form swap that names x0 as its source
    sequence s_seed_swap_x0;
        csr_access && sel_seed && csr_op == SCB_OP_WRITE && !csr_imm && csr_src_x0;
    endsequence

    // Any access to a read-only or hardwired register of this bank
    sequence s_ro_access;
        csr_access && (sel_vendor || sel_arch || sel_impl || sel_hart || sel_cfgptr
                       || sel_seccfgh || sel_perf_hi || sel_intstat);
    endsequence

    sequence s_seccfg_access;
        csr_access && sel_seccfg;
    endsequence

    AST_PERF_HI_ZERO: assert property (csr_access && sel_perf_hi |=> csr_rdata == 32'h0)
        else $error("upper counter half read nonzero");
    AST_CPU_RSVD: assert property (s_cpu_write |=> (cpuctrl_q & ~SCB_CPUCTRL_MASK) == 32'h0)
        else $error("feature control reserved bits set");
    AST_DUMMY_RANGE: assert property (dummy_fire |=> dummy_target_q >= 7'h01
        && dummy_target_q <= {1'b0, $past(interval_mask)} + 7'h01)
        else $error("dummy spacing outside selected range");
    AST_DUMMY_PULSE: assert property (dummy_insert_enable && instr_retired
        && dummy_cnt_q + 7'h01 >= dummy_target_q |=> dummy_insert_req
        ##1 (dummy_insert_req == $past(dummy_fire)))
        else $error("dummy request missing or not a pulse");
    AST_INTEG_FOLLOW: assert property (s_cpu_write |=> integrity_check_enable
        == $past(csr_wdata[SCB_INTEG_BIT]) && pc_hardening_enable == $past(csr_wdata[SCB_PCH_BIT]))
        else $error("integrity or hardening enable did not follow write");
    AST_HINT_SWAP: assert property (hint_match |=> hint_swap && hint_swap_instr[11:7] == 5'h00)
        else $error("hint not replaced by x0 instruction");
    AST_SEED_READ: assert property (csr_access && sel_seed |=> csr_rdata == 32'h0)
        else $error("seed register read nonzero");
    AST_SEED_ILLEGAL: assert property (s_seed_bad |=> csr_illegal)
        else $error("bad seed access not flagged illegal");
    AST_HART_ID: assert property (csr_access && sel_hart |=> csr_rdata == $past(hart_id_in))
        else $error("hart identity mismatch");
    AST_STICKY: assert property (machine_lockdown |=> machine_lockdown)
        else $error("lockdown bit cleared without reset");
    AST_ALERT: assert property (shadow_bad |=> major_alert)
        else $error("shadow mismatch without alert");

    // Seed misuse and read-only writes
    AST_SEED_X0: assert property (s_seed_swap_x0 |=> csr_illegal)
        else $error("seed swap from x0 not flagged illegal");
    AST_RO_LEGAL: assert property (s_ro_access |=> !csr_illegal)
        else $error("read-only access flagged illegal");
    AST_RO_HIT: assert property (s_ro_access |=> csr_hit)
        else $error("bank register access not reported as hit");

    // Identity and hardwired read values
    AST_VENDOR: assert property (csr_access && sel_vendor |=> csr_rdata == VENDOR_ID)
        else $error("vendor identity mismatch");
    AST_ARCH: assert property (csr_access && sel_arch |=> csr_rdata == ARCH_ID)
        else $error("architecture identity mismatch");
    AST_IMPL: assert property (csr_access && sel_impl |=> csr_rdata[31:20] == 12'h000
        && csr_rdata[15:12] == 4'h0 && csr_rdata[7:4] == 4'h0
        && csr_rdata[3:0] == $past(impl_patch_in))
        else $error("implementation version fields wrong");
    AST_CFGPTR: assert property (csr_access && sel_cfgptr |=> csr_rdata == 32'h0)
        else $error("config pointer read nonzero");
    AST_SECCFGH: assert property (csr_access && sel_seccfgh |=> csr_rdata == 32'h0)
        else $error("upper security config read nonzero");
    AST_INTSTAT: assert property (csr_access && sel_intstat |=> csr_rdata[23:0] == 24'h0
        && csr_rdata[31:24] == $past(mil_q))
        else $error("interrupt status fields wrong");

    // Security configuration
    AST_SECCFG_RSVD: assert property (s_seccfg_access |=> csr_rdata[31:3] == 29'h0)
        else $error("security config reserved bits set");
    AST_WL_STICKY: assert property (whitelist_policy |=> whitelist_policy)
        else $error("whitelist bit cleared without reset");

    // Feature enables, their effect on the pulses, and a quiet alert without shadow mismatch
    AST_CT_FOLLOW: assert property (s_cpu_write |=> constant_time_enable
        == $past(csr_wdata[SCB_CT_BIT])
        && dummy_insert_enable == $past(csr_wdata[SCB_DUMMY_EN_BIT])
        && random_hint_replace == $past(csr_wdata[SCB_HINT_BIT]))
        else $error("timing, dummy or hint enable did not follow write");
    AST_HINT_OFF: assert property (!random_hint_replace |=> !hint_swap)
        else $error("hint replaced while disabled");
    AST_DUMMY_OFF: assert property (!dummy_insert_enable |=> !dummy_insert_req)
        else $error("dummy request while disabled");
    AST_ALERT_QUIET: assert property (!shadow_bad |=> !major_alert)
        else $error("alert without shadow mismatch");
endmodule
`default_nettype wire

// >>> rtl/scb_pkg.sv
// Constants for the security and identity CSR bank.
// Assumes a 12-bit CSR address and 32-bit CSR data from the core.
package scb_pkg;
    typedef enum logic [1:0] {SCB_OP_NONE, SCB_OP_WRITE, SCB_OP_SET, SCB_OP_CLEAR} scb_op_t;

    localparam logic [11:0] SCB_ADDR_SECCFG = 12'h747;
    localparam logic [11:0] SCB_ADDR_SECCFGH = 12'h757;
    localparam logic [11:0] SCB_ADDR_PERF_HI_FIRST = 12'hb83;
    localparam logic [11:0] SCB_ADDR_PERF_HI_LAST = 12'hb9f;
    localparam logic [11:0] SCB_ADDR_CPUCTRL = 12'hbf0;
    localparam logic [11:0] SCB_ADDR_SEED0 = 12'hbf9;
    localparam logic [11:0] SCB_ADDR_SEED1 = 12'hbfa;
    localparam logic [11:0] SCB_ADDR_SEED2 = 12'hbfc;
    localparam logic [11:0] SCB_ADDR_VENDOR = 12'hf11;
    localparam logic [11:0] SCB_ADDR_ARCH = 12'hf12;
    localparam logic [11:0] SCB_ADDR_IMPL = 12'hf13;
    localparam logic [11:0] SCB_ADDR_HART = 12'hf14;
    localparam logic [11:0] SCB_ADDR_CFGPTR = 12'hf15;
    localparam logic [11:0] SCB_ADDR_INTSTAT = 12'hfb1;

    localparam int SCB_CT_BIT = 0;
    localparam int SCB_DUMMY_EN_BIT = 1;
    localparam int SCB_HINT_BIT = 2;
    localparam int SCB_PCH_BIT = 3;
    localparam int SCB_INTEG_BIT = 4;
    localparam int SCB_INTERVAL_LSB = 16;
    localparam logic [31:0] SCB_CPUCTRL_MASK = 32'h000f001f;
    localparam logic [31:0] SCB_CPUCTRL_RESET = 32'h00000019;

    localparam int SCB_ML_BIT = 0;
    localparam int SCB_WL_BIT = 1;
    localparam int SCB_RLB_BIT = 2;
    localparam logic [2:0] SCB_SECCFG_RESET = 3'h0;

    localparam int SCB_MIL_LSB = 24;
    localparam int SCB_MAJOR_LSB = 16;
    localparam int SCB_MINOR_LSB = 8;

    localparam logic [31:0] SCB_SEED0_RESET = 32'h00000001;
    localparam logic [31:0] SCB_SEED1_RESET = 32'h00000002;
    localparam logic [31:0] SCB_SEED2_RESET = 32'h00000003;
    localparam logic [31:0] SCB_LFSR_POLY = 32'h80200003;

    localparam logic [6:0] SCB_OPC_OPIMM = 7'h13;
endpackage

// >>> verif/tb_top.sv
// Self-checking bench for the security and identity CSR bank.
// Assumes one design instance on a 100 MHz mclk, driven by this module only.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import scb_pkg::*;
;
    // Identity values are arbitrary neutral choices
    localparam logic [31:0] VID = 32'h00000a5a;
    localparam logic [31:0] AID = 32'h00000333;
    logic mclk, resetn, csr_access, csr_imm, csr_src_x0, csr_rvalid, csr_hit, csr_illegal;
    logic [11:0] csr_addr;
    scb_op_t csr_op;
    logic [31:0] csr_wdata, csr_rdata, hart_id_in, hint_swap_instr, rd;
    logic [3:0] impl_patch_in, dummy_insert_interval;
    logic [7:0] machine_level_active_in;
    logic instr_retired, hint_valid, constant_time_enable, dummy_insert_enable;
    logic random_hint_replace, pc_hardening_enable, integrity_check_enable, dummy_insert_req;
    logic hint_swap, whitelist_policy, machine_lockdown, rule_lock_bypass, major_alert, hit, ill;
    logic [15:0] hint_instr;
    int fail_count = 0;
    int n_checks = 0;
    scb_security_id_csr_bank #(.LEVEL_INTC_EN(1'b1), .PROT_REGION_COUNT(4), .VENDOR_ID(VID),
        .ARCH_ID(AID), .IMPL_MAJOR(4'h3), .IMPL_MINOR(4'h5)) scb_security_id_csr_bank_i (
        .mclk(mclk), .resetn(resetn), .csr_access(csr_access), .csr_addr(csr_addr),
        .csr_op(csr_op), .csr_imm(csr_imm), .csr_src_x0(csr_src_x0), .csr_wdata(csr_wdata),
        .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .csr_hit(csr_hit),
        .csr_illegal(csr_illegal), .hart_id_in(hart_id_in), .impl_patch_in(impl_patch_in),
        .machine_level_active_in(machine_level_active_in), .instr_retired(instr_retired),
        .hint_valid(hint_valid), .hint_instr(hint_instr),
        .constant_time_enable(constant_time_enable), .dummy_insert_enable(dummy_insert_enable),
        .random_hint_replace(random_hint_replace), .pc_hardening_enable(pc_hardening_enable),
        .integrity_check_enable(integrity_check_enable),
        .dummy_insert_interval(dummy_insert_interval), .dummy_insert_req(dummy_insert_req),
        .hint_swap(hint_swap), .hint_swap_instr(hint_swap_instr),
        .whitelist_policy(whitelist_policy), .machine_lockdown(machine_lockdown),
        .rule_lock_bypass(rule_lock_bypass), .major_alert(major_alert));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One access: held over one taking edge, answer sampled just after it
    task automatic acc(input logic [11:0] a, input scb_op_t op, input logic [31:0] wd,
                       input logic imm = 1'b0, input logic x0 = 1'b0);
        @(posedge mclk);
        csr_access <= 1'b1;
        csr_addr <= a;
        csr_op <= op;
        csr_wdata <= wd;
        csr_imm <= imm;
        csr_src_x0 <= x0;
        @(posedge mclk);
        csr_access <= 1'b0;
        csr_op <= SCB_OP_NONE;
        #1;
        rd = csr_rdata;
        hit = csr_hit;
        ill = csr_illegal;
        chk("rvalid", {31'h0, csr_rvalid}, 32'h1);
    endtask
    task automatic do_reset();
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
    endtask
    // Retires one instruction every other cycle; returns retires until a dummy request
    task automatic gap(output int k);
        k = 0;
        while (k < 70)
        begin
            @(posedge mclk);
            instr_retired <= 1'b1;
            @(posedge mclk);
            instr_retired <= 1'b0;
            k++;
            #1;
            if (dummy_insert_req === 1'b1)
                break;
        end
    endtask
    task automatic t_ctrl();
        logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
        acc(SCB_ADDR_CPUCTRL, SCB_OP_NONE, 32'h0);
        chk("ctrl reset", rd, 32'h00000019);
        acc(SCB_ADDR_CPUCTRL, SCB_OP_WRITE, 32'h00070002);
        chk("ctrl old", rd, 32'h00000019);
        chk("ctrl pins", {20'h0, dummy_insert_interval, 3'h0, integrity_check_enable,
            pc_hardening_enable, random_hint_replace, dummy_insert_enable,
            constant_time_enable}, 32'h702);
        acc(SCB_ADDR_CPUCTRL, SCB_OP_WRITE, 32'hffffffff);
        acc(SCB_ADDR_CPUCTRL, SCB_OP_NONE, 32'h0);
        chk("ctrl reserved", rd, 32'h000f001f);
        foreach (codes[i])
        begin
            acc(SCB_ADDR_CPUCTRL, SCB_OP_WRITE, {12'h0, codes[i], 16'h0});
            acc(SCB_ADDR_CPUCTRL, SCB_OP_NONE, 32'h0);
            chk("interval", rd, {12'h0, codes[i], 16'h0});
        end
        $display("test ctrl done");
    endtask
    task automatic t_dummy();
        int k;
        do_reset();
        acc(SCB_ADDR_CPUCTRL, SCB_OP_WRITE, 32'h00000002);
        gap(k);
        chk("first gap", k, 4);
        gap(k);
        chk("gap in 1-4", {31'h0, k >= 1 && k <= 4}, 32'h1);
        acc(SCB_ADDR_CPUCTRL, SCB_OP_WRITE, 32'h000f0002);
        gap(k);
        gap(k);
        chk("gap in 1-64", {31'h0, k >= 1 && k <= 64}, 32'h1);
        acc(SCB_ADDR_CPUCTRL, SCB_OP_WRITE, 32'h00000000);
        gap(k);
        chk("disabled gap", k, 70);
        $display("test dummy done");
    endtask
    task automatic t_hint();
        logic [31:0] cases [3] = '{32'h1_0006, 32'h1_0002, 32'h0_0006};
        foreach (cases[i])
        begin
            acc(SCB_ADDR_CPUCTRL, SCB_OP_WRITE, {29'h0, cases[i][16], 2'h0});
            @(posedge mclk);
            hint_valid <= 1'b1;
            hint_instr <= cases[i][15:0];
            @(posedge mclk);
            hint_valid <= 1'b0;
            #1;
            chk("hint swap", {31'h0, hint_swap}, {31'h0, i == 0});
            if (i == 0)
                chk("swap op", {20'h0, hint_swap_instr[11:0]},
                    {20'h0, 5'h0, SCB_OPC_OPIMM});
        end
        $display("test hint done");
    endtask
    task automatic t_seed();
        logic [11:0] sa [3] = '{SCB_ADDR_SEED0, SCB_ADDR_SEED1, SCB_ADDR_SEED2};
        foreach (sa[i])
        begin
            acc(sa[i], SCB_OP_WRITE, 32'h1234abcd);
            chk("seed read", rd, 32'h0);
            chk("seed swap ok", {31'h0, ill}, 32'h0);
            acc(sa[i], SCB_OP_SET, 32'h1);
            chk("seed set", {31'h0, ill}, 32'h1);
            acc(sa[i], SCB_OP_CLEAR, 32'h1);
            chk("seed clear", {31'h0, ill}, 32'h1);
            acc(sa[i], SCB_OP_WRITE, 32'h5, 1'b1, 1'b0);
            chk("seed imm", {31'h0, ill}, 32'h1);
            acc(sa[i], SCB_OP_WRITE, 32'h0, 1'b0, 1'b1);
            chk("seed x0", {31'h0, ill}, 32'h1);
        end
        $display("test seed done");
    endtask
    task automatic t_ro();
        logic [11:0] ad [10] = '{SCB_ADDR_PERF_HI_FIRST, 12'hb90, SCB_ADDR_PERF_HI_LAST,
            SCB_ADDR_SECCFGH, SCB_ADDR_CFGPTR, SCB_ADDR_VENDOR, SCB_ADDR_ARCH, SCB_ADDR_IMPL,
            SCB_ADDR_HART, SCB_ADDR_INTSTAT};
        logic [31:0] ex [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, VID, AID, 32'h00030509,
            32'h0000c0de, 32'ha5000000};
        foreach (ad[i])
        begin
            acc(ad[i], SCB_OP_WRITE, 32'hffffffff);
            chk("ro write legal", {31'h0, ill}, 32'h0);
            acc(ad[i], SCB_OP_NONE, 32'h0);
            chk("ro value", rd, ex[i]);
            chk("ro hit", {31'h0, hit}, 32'h1);
        end
        acc(12'h123, SCB_OP_NONE, 32'h0);
        chk("unmapped", {rd[30:0], hit}, 32'h0);
        $display("test ro done");
    endtask
    task automatic t_seccfg();
        acc(SCB_ADDR_SECCFG, SCB_OP_WRITE, 32'h00000007);
        acc(SCB_ADDR_SECCFG, SCB_OP_WRITE, 32'h00000300);
        chk("seccfg set", rd, 32'h7);
        acc(SCB_ADDR_SECCFG, SCB_OP_CLEAR, 32'h00000003);
        chk("seccfg bits", rd, 32'h3);
        chk("seccfg pins", {29'h0, rule_lock_bypass, whitelist_policy, machine_lockdown},
            32'h3);
        do_reset();
        acc(SCB_ADDR_SECCFG, SCB_OP_NONE, 32'h0);
        chk("seccfg reset", rd, 32'h0);
        chk("alert", {31'h0, major_alert}, 32'h0);
        $display("test seccfg done");
    endtask
    initial
    begin
        resetn = 1'b0;
        csr_access = 1'b0;
        csr_addr = 12'h0;
        csr_op = SCB_OP_NONE;
        csr_imm = 1'b0;
        csr_src_x0 = 1'b0;
        csr_wdata = 32'h0;
        hart_id_in = 32'h0000c0de;
        impl_patch_in = 4'h9;
        machine_level_active_in = 8'ha5;
        instr_retired = 1'b0;
        hint_valid = 1'b0;
        hint_instr = 16'h0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        t_ctrl();
        t_dummy();
        t_hint();
        t_seed();
        t_ro();
        t_seccfg();
        close_out();
    end
endmodule
`default_nettype wire
